/* rtl/sbia_bridge.v */
// Purpose: indirect access bridge from a register port to the shared bus
// Assumes: register port strobes are one cycle, synchronous to clk_sys
// Notes:   all outputs registered; one shared-bus access in flight
`timescale 1ns/100ps
`default_nettype none
`include "sbia_regs.vh"

module sbia_bridge (
  // clock and reset
  input  wire                clk_sys,
  input  wire                reset_n,
  // register port
  input  wire [`SBIA_AW-1:0] reg_addr,
  input  wire [31:0]         reg_wdata,
  input  wire                reg_wr,
  input  wire                reg_rd,
  output reg  [31:0]         reg_rdata_q,
  // interrupt
  output reg                 irq_q,
  // shared bus
  output wire                sb_req,
  output wire                sb_we,
  output wire [31:0]         sb_addr,
  output wire [31:0]         sb_wdata,
  input  wire                sb_gnt,
  input  wire                sb_ack,
  input  wire                sb_err,
  input  wire [31:0]         sb_rdata
);

  reg  [31:0] addr_q;
  reg  [31:0] data_q;
  reg         busy_q;
  reg         err_q;
  reg  [`SBIA_IRQ_BITS-1:0] irq_stat_q;
  reg  [`SBIA_IRQ_BITS-1:0] irq_mask_q;

  wire        done;
  wire        done_err;
  wire [31:0] done_rdata;

  // decode of the data registers
  wire sel_data = (reg_addr == `SBIA_OFF_DATA);
  wire sel_inc  = (reg_addr == `SBIA_OFF_DATA_INC);
  wire sel_pas  = (reg_addr == `SBIA_OFF_DATA_PAS);
  wire sel_launch = sel_data || sel_inc;

  // a launch is only taken while idle; busy accesses are refused
  wire launch    = (reg_wr || reg_rd) && sel_launch && !busy_q;
  wire launch_we = reg_wr;

  // written word goes straight to the bus, so the store and the launch agree
  wire [31:0] launch_wdata = reg_wr ? reg_wdata : data_q;

  sbia_bus_master u_master (
    .clk_sys      (clk_sys),
    .reset_n      (reset_n),
    .start        (launch),
    .start_we     (launch_we),
    .start_addr   (addr_q),
    .start_wdata  (launch_wdata),
    .done_q       (done),
    .done_err_q   (done_err),
    .done_rdata_q (done_rdata),
    .sb_req_q     (sb_req),
    .sb_we_q      (sb_we),
    .sb_addr_q    (sb_addr),
    .sb_wdata_q   (sb_wdata),
    .sb_gnt       (sb_gnt),
    .sb_ack       (sb_ack),
    .sb_err       (sb_err),
    .sb_rdata     (sb_rdata)
  );

  // register write strobes, decoded once
  wire wr_status  = reg_wr && (reg_addr == `SBIA_OFF_STATUS);
  wire wr_addr    = reg_wr && (reg_addr == `SBIA_OFF_ADDR);
  wire wr_pas     = reg_wr && sel_pas;
  wire wr_err_clr = wr_status && reg_wdata[`SBIA_BIT_ERR];

  // next values of the access state
  reg         busy_d;
  reg  [31:0] addr_d;
  reg  [31:0] data_d;
  reg         err_d;

  // busy spans the launch up to the cycle the answer is loaded
  always @* begin
    busy_d = busy_q;
    if (launch) begin
      busy_d = 1'b1;
    end else if (done) begin
      busy_d = 1'b0;
    end
  end

  // address register; a refused busy access never steps it
  always @* begin
    addr_d = addr_q;
    if (wr_addr) begin
      addr_d = reg_wdata;
    end else if (launch && sel_inc) begin
      addr_d = addr_q + `SBIA_ADDR_STEP;
    end
  end

  // shared data word; a bus answer can only arrive while busy, when
  // cpu writes are refused, so the two never collide
  always @* begin
    data_d = data_q;
    if (done && done_err) begin
      data_d = `SBIA_ERR_WORD;
    end else if (done && !sb_we) begin
      data_d = done_rdata;
    end else if (wr_pas && !busy_q) begin
      data_d = reg_wdata;
    end else if (launch && launch_we) begin
      data_d = reg_wdata;
    end
  end

  // error flag: sticky debug aid; a new error wins over its clear
  always @* begin
    err_d = err_q;
    if (done && done_err) begin
      err_d = 1'b1;
    end else if (wr_err_clr) begin
      err_d = 1'b0;
    end
  end

  // access state bank
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
      addr_q <= `SBIA_ADDR_RST;
      data_q <= `SBIA_DATA_RST;
      err_q  <= 1'b0;
    end else begin
      busy_q <= busy_d;
      addr_q <= addr_d;
      data_q <= data_d;
      err_q  <= err_d;
    end
  end

  // interrupt status, set wins over write-one-to-clear
  wire [`SBIA_IRQ_BITS-1:0] irq_evt;
  assign irq_evt[`SBIA_IRQ_DONE] = done;
  assign irq_evt[`SBIA_IRQ_ERR]  = done && done_err;

  genvar gi;
  generate
    for (gi = 0; gi < `SBIA_IRQ_BITS; gi = gi + 1) begin : g_irq
      always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          irq_stat_q[gi] <= 1'b0;
        end else if (irq_evt[gi]) begin
          irq_stat_q[gi] <= 1'b1;
        end else if (reg_wr && reg_addr == `SBIA_OFF_IRQ_STAT
                     && reg_wdata[gi]) begin
          irq_stat_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_mask_q <= `SBIA_IRQ_RST;
    end else if (reg_wr && reg_addr == `SBIA_OFF_IRQ_MASK) begin
      irq_mask_q <= reg_wdata[`SBIA_IRQ_BITS-1:0];
    end
  end

  // level interrupt from the next status and mask, so it is registered
  reg [`SBIA_IRQ_BITS-1:0] irq_stat_d;
  reg [`SBIA_IRQ_BITS-1:0] irq_mask_d;
  integer ii;
  always @* begin
    irq_stat_d = irq_stat_q;
    irq_mask_d = irq_mask_q;
    if (reg_wr && reg_addr == `SBIA_OFF_IRQ_MASK) begin
      irq_mask_d = reg_wdata[`SBIA_IRQ_BITS-1:0];
    end
    for (ii = 0; ii < `SBIA_IRQ_BITS; ii = ii + 1) begin
      if (irq_evt[ii]) begin
        irq_stat_d[ii] = 1'b1;
      end else if (reg_wr && reg_addr == `SBIA_OFF_IRQ_STAT
                   && reg_wdata[ii]) begin
        irq_stat_d[ii] = 1'b0;
      end
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_stat_d & irq_mask_d);
    end
  end

  // read data, valid the cycle after the read strobe only
  reg [31:0] rdata_d;
  always @* begin
    rdata_d = `SBIA_ZERO32;
    if (reg_rd) begin
      if (reg_addr == `SBIA_OFF_STATUS) begin
        rdata_d[`SBIA_BIT_BUSY] = busy_q;
        rdata_d[`SBIA_BIT_ERR]  = err_q;
      end else if (reg_addr == `SBIA_OFF_ADDR) begin
        rdata_d = addr_q;
      end else if (sel_data || sel_inc || sel_pas) begin
        rdata_d = busy_q ? `SBIA_ERR_WORD : data_q;
      end else if (reg_addr == `SBIA_OFF_IRQ_STAT) begin
        rdata_d[`SBIA_IRQ_BITS-1:0] = irq_stat_q;
      end else if (reg_addr == `SBIA_OFF_IRQ_MASK) begin
        rdata_d[`SBIA_IRQ_BITS-1:0] = irq_mask_q;
      end
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_q <= `SBIA_ZERO32;
    end else begin
      reg_rdata_q <= rdata_d;
    end
  end

endmodule // sbia_bridge
`default_nettype wire

/* rtl/sbia_regs.vh */
// Purpose: constants for the shared bus indirect access bridge
// Assumes: word-indexed register port, 50 MHz system clock
// Notes:   offsets are register indices on the plain register port
`ifndef SBIA_REGS_VH
`define SBIA_REGS_VH

`define SBIA_AW                 3
`define SBIA_OFF_STATUS         3'h0
`define SBIA_OFF_ADDR           3'h1
`define SBIA_OFF_DATA           3'h2
`define SBIA_OFF_DATA_INC       3'h3
`define SBIA_OFF_DATA_PAS       3'h4
`define SBIA_OFF_IRQ_STAT       3'h5
`define SBIA_OFF_IRQ_MASK       3'h6

`define SBIA_BIT_BUSY           0
`define SBIA_BIT_ERR            1
`define SBIA_IRQ_BITS           2
`define SBIA_IRQ_DONE           0
`define SBIA_IRQ_ERR            1

`define SBIA_ERR_WORD           32'h8888_8888
`define SBIA_ADDR_STEP          32'h0000_0004
`define SBIA_ZERO32             32'h0000_0000
`define SBIA_ADDR_RST           32'h0000_0000
`define SBIA_DATA_RST           32'h0000_0000
`define SBIA_IRQ_RST            2'h0

`endif

/* rtl/sbia_bus_master.v */
// Purpose: shared bus master that issues one word access at a time
// Assumes: bus slave answers with ack or err while req is held
// Notes:   request held until grant and answer; one outstanding only
`timescale 1ns/100ps
`default_nettype none
`include "sbia_regs.vh"

module sbia_bus_master (
  // clock and reset
  input  wire        clk_sys,
  input  wire        reset_n,
  // launch side
  input  wire        start,
  input  wire        start_we,
  input  wire [31:0] start_addr,
  input  wire [31:0] start_wdata,
  output reg         done_q,
  output reg         done_err_q,
  output reg  [31:0] done_rdata_q,
  // shared bus
  output reg         sb_req_q,
  output reg         sb_we_q,
  output reg  [31:0] sb_addr_q,
  output reg  [31:0] sb_wdata_q,
  input  wire        sb_gnt,
  input  wire        sb_ack,
  input  wire        sb_err,
  input  wire [31:0] sb_rdata
);

  localparam ST_IDLE = 1'b0;
  localparam ST_WAIT = 1'b1;

  reg state_q;

  // request stays up through arbitration until the slave answers
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q      <= ST_IDLE;
      sb_req_q     <= 1'b0;
      sb_we_q      <= 1'b0;
      sb_addr_q    <= `SBIA_ZERO32;
      sb_wdata_q   <= `SBIA_ZERO32;
      done_q       <= 1'b0;
      done_err_q   <= 1'b0;
      done_rdata_q <= `SBIA_ZERO32;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q    <= ST_WAIT;
            sb_req_q   <= 1'b1;
            sb_we_q    <= start_we;
            sb_addr_q  <= start_addr;
            sb_wdata_q <= start_wdata;
          end
        end
        default: begin
          if (sb_gnt && (sb_ack || sb_err)) begin
            state_q      <= ST_IDLE;
            sb_req_q     <= 1'b0;
            done_q       <= 1'b1;
            done_err_q   <= sb_err;
            done_rdata_q <= sb_rdata;
          end
        end
      endcase
    end
  end

endmodule // sbia_bus_master
`default_nettype wire

/* testbench/sbia_bridge_sva.sv */
// Purpose: port assertions for sbia_bridge
// Assumes: busy spans launch to one cycle after the bus answer
// Notes:   idle means no bus request now nor in the cycle before
`timescale 1ns/100ps
`default_nettype none
`include "sbia_regs.vh"
module sbia_bridge_sva (
  // clock and reset
  input wire logic                clk_sys,
  input wire logic                reset_n,
  // register port
  input wire logic [`SBIA_AW-1:0] reg_addr,
  input wire logic [31:0]         reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [31:0]         reg_rdata_q,
  // shared bus
  input wire logic                sb_req,
  input wire logic                sb_we,
  input wire logic [31:0]         sb_addr,
  input wire logic [31:0]         sb_wdata,
  input wire logic                sb_gnt,
  input wire logic                sb_ack,
  input wire logic                sb_err
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  wire dat = reg_addr == `SBIA_OFF_DATA || reg_addr == `SBIA_OFF_DATA_INC;
  wire pas = reg_addr == `SBIA_OFF_DATA_PAS;
  wire ans = sb_req && sb_gnt && (sb_ack || sb_err);
  a_req_held:
    assert property (sb_req && !ans |=> sb_req && $stable(sb_addr)
      && $stable(sb_we) && $stable(sb_wdata)) else $error("request moved");
  a_wr_launch:
    assert property (reg_wr && reg_addr == `SBIA_OFF_DATA && !sb_req
      && !$past(sb_req) |=> sb_req && sb_we && sb_wdata == $past(reg_wdata))
      else $error("write not launched");
  a_rd_launch:
    assert property (reg_rd && dat && !sb_req && !$past(sb_req)
      |=> sb_req && !sb_we) else $error("read not launched");
  a_pas_quiet:
    assert property ((reg_wr || reg_rd) && pas && !sb_req && !$past(sb_req)
      |=> !sb_req) else $error("passive access launched");
  a_launch_cause:
    assert property ($rose(sb_req) |-> $past((reg_wr || reg_rd) && dat))
      else $error("request without cause");
  a_busy_read:
    assert property (reg_rd && (dat || pas) && sb_req
      |=> reg_rdata_q == `SBIA_ERR_WORD) else $error("busy read not pattern");
  a_req_drop:
    assert property (ans |=> !sb_req ##1 !sb_req) else $error("request kept");
  a_answer_bound:
    assert property ($rose(sb_req) |-> ##[1:40] !sb_req)
      else $error("request never ended");
endmodule // sbia_bridge_sva
bind sbia_bridge sbia_bridge_sva u_sva (.clk_sys, .reset_n, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .sb_req, .sb_we, .sb_addr,
  .sb_wdata, .sb_gnt, .sb_ack, .sb_err);
`default_nettype wire

/* testbench/sbia_bus_slave.sv */
// Purpose: shared bus slave with arbitration stall and error hole
// Assumes: one request held until answered
// Notes:   address nibble f is a hole answering with error
`timescale 1ns/100ps
`default_nettype none
module sbia_bus_slave (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // shared bus
  input  wire logic        sb_req,
  input  wire logic        sb_we,
  input  wire logic [31:0] sb_addr,
  input  wire logic [31:0] sb_wdata,
  output logic             sb_gnt,
  output logic             sb_ack,
  output logic             sb_err,
  output logic [31:0]      sb_rdata,
  // stall length
  input  wire logic [2:0]  dly
);
  logic [31:0] mem [0:15];
  logic [2:0]  cnt_q;
  wire         hole = sb_addr[31:28] == 4'hf;
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 3'h0;
      sb_gnt <= 1'b0;
      sb_ack <= 1'b0;
      sb_err <= 1'b0;
      sb_rdata <= 32'h0000_0000;
    end else begin
      sb_gnt <= 1'b0;
      sb_ack <= 1'b0;
      sb_err <= 1'b0;
      // toggling keeps stale data from ever passing as an answer
      sb_rdata <= ~sb_rdata;
      if (sb_req && !sb_gnt) begin
        if (cnt_q < dly) begin
          cnt_q <= cnt_q + 3'h1;
        end else begin
          cnt_q <= 3'h0;
          sb_gnt <= 1'b1;
          sb_ack <= !hole;
          sb_err <= hole;
          if (!hole) sb_rdata <= mem[sb_addr[5:2]];
          if (!hole && sb_we) mem[sb_addr[5:2]] <= sb_wdata;
        end
      end
    end
  end
endmodule // sbia_bus_slave
`default_nettype wire

/* testbench/sbia_bridge_tb_top.sv */
// Purpose: self-checking bench for sbia_bridge
// Assumes: read data is valid only in the cycle after the strobe
// Notes:   reads queue their expectation for the monitor
`timescale 1ns/100ps
`default_nettype none
`include "sbia_regs.vh"
module sbia_bridge_tb_top;
  localparam logic [2:0] r_st = `SBIA_OFF_STATUS;
  localparam logic [2:0] r_ad = `SBIA_OFF_ADDR;
  localparam logic [2:0] r_dt = `SBIA_OFF_DATA;
  localparam logic [2:0] r_in = `SBIA_OFF_DATA_INC;
  localparam logic [2:0] r_pa = `SBIA_OFF_DATA_PAS;
  localparam logic [2:0] r_is = `SBIA_OFF_IRQ_STAT;
  localparam logic [2:0] r_mk = `SBIA_OFF_IRQ_MASK;
  logic        clk_sys = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [2:0]  reg_addr = 3'h0, dly = 3'h0;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata_q, sb_addr, sb_wdata;
  logic [31:0] sb_rdata, x, e, d [0:3], exp_q [$];
  logic        irq_q, sb_req, sb_we, sb_gnt, sb_ack, sb_err, rd_seen = 1'b0;
  int          num_errors = 0, samples_checked = 0, cyc = 0, seed = 35241, i;
  always #10 clk_sys = ~clk_sys;
  sbia_bridge dut (.clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata_q, .irq_q, .sb_req, .sb_we, .sb_addr, .sb_wdata,
    .sb_gnt, .sb_ack, .sb_err, .sb_rdata);
  sbia_bus_slave u_slave (.clk_sys, .reset_n, .sb_req, .sb_we, .sb_addr,
    .sb_wdata, .sb_gnt, .sb_ack, .sb_err, .sb_rdata, .dly);
  task print_verdict;
    if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // for reads v is the expected data
  task op(input logic w, input logic [2:0] a, input logic [31:0] v);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= v;
    dly <= 3'($random(seed));
    if (!w) exp_q.push_back(v);
    @(posedge clk_sys);
  endtask
  task wt;
    int k;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    for (k = 0; k < 40 && sb_req !== 1'b0; k++) @(posedge clk_sys);
    repeat (2) @(posedge clk_sys);
  endtask
  task chk_irq(input logic v);
    samples_checked++;
    if (irq_q !== v) begin
      num_errors++;
      $display("CHECK FAILED irq_q exp %b got %b", v, irq_q);
    end
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (rd_seen) begin
      e = exp_q.pop_front();
      samples_checked++;
      if (reg_rdata_q !== e) begin
        num_errors++;
        $display("CHECK FAILED reg_rdata_q exp %h got %h", e, reg_rdata_q);
      end
    end
    rd_seen <= reg_rd;
    if (cyc == 3000) begin
      num_errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    op(0, r_st, `SBIA_ZERO32);
    op(0, r_ad, `SBIA_ADDR_RST);
    op(1, 3'h7, 32'hffff_ffff);
    op(0, 3'h7, `SBIA_ZERO32);
    op(1, r_ad, `SBIA_ZERO32);
    for (i = 0; i < 4; i++) begin
      d[i] = $random(seed);
      op(1, r_in, d[i]);
      wt();
    end
    op(0, r_ad, 32'h0000_0010);
    op(1, r_ad, `SBIA_ZERO32);
    op(0, r_in, d[3]);
    op(0, r_in, `SBIA_ERR_WORD);
    wt();
    op(0, r_st, `SBIA_ZERO32);
    op(0, r_pa, d[0]);
    op(0, r_ad, 32'h0000_0004);
    for (i = 1; i < 4; i++) begin
      op(0, r_in, d[i-1]);
      wt();
    end
    op(0, r_pa, d[3]);
    x = $random(seed);
    op(1, r_ad, 32'h0000_0020);
    op(1, r_dt, x);
    op(1, r_dt, ~x);
    op(1, r_pa, ~x);
    wt();
    op(0, r_ad, 32'h0000_0020);
    op(1, r_pa, `SBIA_ZERO32);
    op(0, r_dt, `SBIA_ZERO32);
    wt();
    op(0, r_pa, x);
    op(1, r_mk, 32'h0000_0002);
    op(1, r_ad, 32'hf000_0000);
    op(0, r_dt, x);
    wt();
    chk_irq(1'b1);
    op(0, r_pa, `SBIA_ERR_WORD);
    op(0, r_st, 32'h0000_0002);
    op(1, r_is, 32'h0000_0003);
    op(1, r_st, 32'h0000_0002);
    wt();
    chk_irq(1'b0);
    op(0, r_st, `SBIA_ZERO32);
    op(0, r_is, `SBIA_ZERO32);
    op(1, r_mk, `SBIA_ZERO32);
    op(1, r_ad, `SBIA_ZERO32);
    op(1, r_dt, d[0]);
    wt();
    chk_irq(1'b0);
    op(0, r_is, 32'h0000_0001);
    op(1, r_mk, 32'h0000_0001);
    wt();
    chk_irq(1'b1);
    wt();
    print_verdict();
  end
endmodule // sbia_bridge_tb_top
`default_nettype wire
